// ---- hdl/energy_sync.sv ----
/*
  Two-flop synchronizer for the media signal-energy level.
  Assumes the input is asynchronous to the core clock.
*/
`timescale 1ns/1ps
module energy_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_reg;
  // ****************************************************************
  // Synchronizer; first flop feeds only the second
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : energy_sync

// ---- hdl/phy_link_power_save_fsm.sv ----
/*
  Per-port automatic power-save state machine for a copper PHY: low power,
  link-partner wake-up and normal states, with sleep, wake and link timers.
  Assumes a 200 MHz core clock, synchronous inputs except media energy,
  and a register port whose read data is taken the cycle after the strobe.
*/
`timescale 1ns/1ps
module phy_link_power_save_fsm
  import power_save_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic I_MEDIA_ENERGY,
  input wire logic I_LINK_UP,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic O_LOW_POWER,
  output logic O_MANUAL_PD,
  output logic O_FLP_BURST,
  output logic O_PAIR_B,
  output logic [2:0] O_STATE
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  state_type state_reg;
  state_type state_next;
  logic [31:0] ctrl_reg;
  logic [31:0] rdata_next;
  logic energy_s;
  logic [15:0] rnd;
  logic [31:0] ms_cnt_reg;
  logic ms_tick;
  logic [12:0] dur_reg;
  logic [12:0] dur_next;
  logic dur_done;
  logic [4:0] gap_reg;
  logic [1:0] burst_cnt_reg;
  logic flp_burst_reg;
  logic pair_b_reg;
  logic burst_due;
  logic en;
  logic aneg_en;
  logic entering;
  logic [7:0] jitter;
  logic [12:0] sleep_ms;
  logic [12:0] wake_ms;
  logic [12:0] lto_ms;
  logic [1:0] lto_sel;
  logic link_lost_timeout;

  // Duration of a two-bit timer field: base times (code + 1)
  function automatic logic [12:0] sel_ms(input logic [1:0] sel, input logic [12:0] base);
    logic [14:0] prod;
    prod = 15'(base) * (15'(sel) + 15'h0001);
    return prod[12:0];
  endfunction : sel_ms

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  energy_sync u_energy_sync (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_async(I_MEDIA_ENERGY),
    .o_sync(energy_s)
  );

  sleep_lfsr u_sleep_lfsr (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .o_value(rnd)
  );

  // ****************************************************************
  // Control field decode
  // ****************************************************************
  assign en = ctrl_reg[CTRL_EN_BIT];
  assign aneg_en = ctrl_reg[CTRL_ANEG_BIT];
  // Two separate bits make up the link timeout code
  assign lto_sel = {ctrl_reg[CTRL_LTO_HI_BIT], ctrl_reg[CTRL_LTO_LO_BIT]};
  // Jitter folded into 0..140, mapped to -80..+60 ms around nominal
  assign jitter = (rnd[7:0] >= JITTER_SPAN) ? rnd[7:0] - JITTER_SPAN : rnd[7:0];
  assign sleep_ms = sel_ms(ctrl_reg[CTRL_SLEEP_LSB +: 2], SLEEP_BASE_MS)
                    - JITTER_NEG_MS + {5'h00, jitter};
  assign wake_ms = sel_ms(ctrl_reg[CTRL_WAKE_LSB +: 2], WAKE_BASE_MS);
  assign lto_ms = sel_ms(lto_sel, LTO_BASE_MS);

  // ****************************************************************
  // Register port
  // ****************************************************************
  // Management access is never gated by state, so it works in low power
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      ctrl_reg <= CTRL_RESET;
    end else if (I_WR && I_ADDR == ADDR_CTRL) begin
      ctrl_reg <= I_WDATA & CTRL_MASK;
    end
  end

  // Read mux; unmapped addresses read zero
  assign rdata_next = !I_RD ? 32'h0000_0000 :
                      (I_ADDR == ADDR_CTRL) ? ctrl_reg :
                      (I_ADDR == ADDR_STATUS) ?
                        {25'h0000000, burst_cnt_reg, I_LINK_UP, energy_s, 3'(state_reg)} :
                      32'h0000_0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_RDATA <= rdata_next;
    end
  end

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  // One prescaler shared by all timers keeps the duration counter small
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST || entering || ms_tick) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // State machine
  // ****************************************************************
  assign dur_done = (dur_reg == 13'h0000) && ms_tick;
  // Autoneg off in normal keeps the port up even after a drop
  assign link_lost_timeout = aneg_en && !I_LINK_UP && dur_done;
  assign entering = (state_next != state_reg);

  // Next-state logic; energy has priority over the sleep/wake timers
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOW: begin
        if (!en) begin
          state_next = ST_NORM;
        end else if (energy_s) begin
          state_next = ST_NORM;
        end else if (dur_done) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!en) begin
          state_next = ST_NORM;
        end else if (energy_s) begin
          state_next = ST_NORM;
        end else if (dur_done) begin
          state_next = ST_LOW;
        end
      end
      ST_NORM: begin
        if (en && link_lost_timeout) begin
          state_next = ST_LOW;
        end
      end
      default: begin
        state_next = ST_LOW;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      state_reg <= ST_LOW;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Duration counter
  // ****************************************************************
  // Reloaded on every state entry; in normal it restarts while link is up
  always_comb begin
    dur_next = dur_reg;
    if (entering) begin
      case (state_next)
        ST_LOW: dur_next = sleep_ms;
        ST_WAKE: dur_next = wake_ms;
        ST_NORM: dur_next = lto_ms;
        default: dur_next = sleep_ms;
      endcase
    end else if (state_reg == ST_NORM && I_LINK_UP) begin
      dur_next = lto_ms;
    end else if (ms_tick && dur_reg != 13'h0000) begin
      dur_next = dur_reg - 13'h0001;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      dur_reg <= sel_ms(CTRL_RESET[CTRL_SLEEP_LSB +: 2], SLEEP_BASE_MS);
    end else begin
      dur_reg <= dur_next;
    end
  end

  // ****************************************************************
  // Fast link pulse bursts
  // ****************************************************************
  // A burst on entry, then one per gap, capped at three per wake visit
  assign burst_due = (state_reg == ST_WAKE) && (burst_cnt_reg < MAX_BURSTS)
                     && (gap_reg == 5'h00);

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST || state_reg != ST_WAKE) begin
      gap_reg <= 5'h00;
      burst_cnt_reg <= 2'h0;
      flp_burst_reg <= 1'b0;
    end else begin
      flp_burst_reg <= burst_due;
      if (burst_due) begin
        gap_reg <= BURST_GAP_MS;
        burst_cnt_reg <= burst_cnt_reg + 2'h1;
      end else if (ms_tick && gap_reg != 5'h00) begin
        gap_reg <= gap_reg - 5'h01;
      end
    end
  end

  // Pair select flips with each burst so A and B alternate
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      pair_b_reg <= 1'b0;
    end else if (burst_due) begin
      pair_b_reg <= !pair_b_reg;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_FLP_BURST = flp_burst_reg;
  assign O_PAIR_B = pair_b_reg;
  assign O_STATE = 3'(state_reg);
  // Digital blocks sleep outside normal; manual power-down is separate
  assign O_LOW_POWER = (state_reg != ST_NORM);
  assign O_MANUAL_PD = ctrl_reg[CTRL_PD_BIT];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_reset_low;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    $fell(I_SRST) |-> state_reg == ST_LOW;
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("state not low power after reset");

  property p_one_state;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    $onehot(state_reg);
  endproperty
  a_one_state: assert property (p_one_state)
    else $error("state is not one of three");

  property p_energy_wakes;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    (state_reg != ST_NORM && en && energy_s) |=> state_reg == ST_NORM;
  endproperty
  a_energy_wakes: assert property (p_energy_wakes)
    else $error("energy did not reach normal");

  property p_energy_path;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    (en && state_reg != ST_NORM && !I_MEDIA_ENERGY && !energy_s)
      ##1 I_MEDIA_ENERGY [*3] |=> state_reg == ST_NORM;
  endproperty
  a_energy_path: assert property (p_energy_path)
    else $error("synchronized energy path too slow");

  property p_aneg_off_stays;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    (state_reg == ST_NORM && !aneg_en) |=> state_reg == ST_NORM;
  endproperty
  a_aneg_off_stays: assert property (p_aneg_off_stays)
    else $error("left normal with autoneg off");

  property p_link_up_stays;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    (state_reg == ST_NORM && $past(I_LINK_UP)) |=> state_reg == ST_NORM;
  endproperty
  a_link_up_stays: assert property (p_link_up_stays)
    else $error("left normal without link timeout");

  property p_burst_in_wake;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    $rose(state_reg == ST_WAKE) |=> O_FLP_BURST && $changed(O_PAIR_B);
  endproperty
  a_burst_in_wake: assert property (p_burst_in_wake)
    else $error("no burst on wake entry");

  property p_burst_cap;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    O_FLP_BURST |-> $past(state_reg == ST_WAKE) && $past(burst_cnt_reg) < MAX_BURSTS;
  endproperty
  a_burst_cap: assert property (p_burst_cap)
    else $error("burst outside wake or over cap");

  property p_disabled_normal;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    !en |=> state_reg == ST_NORM;
  endproperty
  a_disabled_normal: assert property (p_disabled_normal)
    else $error("disabled port not in normal");

  property p_status_read;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    (I_RD && I_ADDR == ADDR_STATUS) |=> O_RDATA[2:0] == $past(O_STATE);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong state");

  property p_pair_toggle;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    O_FLP_BURST |-> $changed(O_PAIR_B);
  endproperty
  a_pair_toggle: assert property (p_pair_toggle)
    else $error("burst did not switch pair");

  property p_timer_restart;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    $changed(state_reg) |-> ms_cnt_reg == 32'h0000_0000;
  endproperty
  a_timer_restart: assert property (p_timer_restart)
    else $error("tick prescaler not restarted on entry");

  property p_wake_returns;
    @(posedge I_REF_CLK) disable iff (I_SRST)
    (state_reg == ST_WAKE && en && !energy_s && dur_done) |=> state_reg == ST_LOW;
  endproperty
  a_wake_returns: assert property (p_wake_returns)
    else $error("wake state did not return to low power");
endmodule : phy_link_power_save_fsm

// ---- hdl/power_save_pkg.sv ----
/*
  Constants for the per-port copper power-save state machine: register map,
  field positions, reset values, state codes and timing figures.
  Assumes a 200 MHz core clock and a plain address/strobe register port.
*/
// How it works
// - Per-port enable bit, writable any time
// - Exactly one of three states when enabled
// - Alternate sleep and wake until energy; 2 s
// - Signal energy moves port to normal
// - Link loss returns to low power after timeout
// - Reset starts in low power
// - Forced mode: reach normal, then stay
// - Autoneg off in normal: stay on drop
// - Each wake interval sends fast pulse bursts
// - Manual power-down bit stays independent
// - Signal detect drives automatic power-down
// - Two-bit sleep field, randomized duration
// - Up to three bursts, alternating pairs A/B
// - Link timeout set by two separate bits
// - Low states power down; management stays alive
package power_save_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ANEG_BIT = 1;
  localparam int CTRL_PD_BIT = 2;
  localparam int CTRL_SLEEP_LSB = 4;
  localparam int CTRL_WAKE_LSB = 6;
  localparam int CTRL_LTO_HI_BIT = 8;
  localparam int CTRL_LTO_LO_BIT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0012;
  localparam logic [31:0] CTRL_MASK = 32'h0000_03F7;
  // ****************************************************************
  // States and timing
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_LOW = 3'b001,
    ST_WAKE = 3'b010,
    ST_NORM = 3'b100
  } state_type;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES_DEF = MS_PS / CLK_PERIOD_PS;
  localparam logic [12:0] SLEEP_BASE_MS = 13'h03E8;
  localparam logic [12:0] WAKE_BASE_MS = 13'h0010;
  localparam logic [12:0] LTO_BASE_MS = 13'h03E8;
  localparam logic [12:0] JITTER_NEG_MS = 13'h0050;
  localparam logic [7:0] JITTER_SPAN = 8'h8D;
  localparam logic [4:0] BURST_GAP_MS = 5'h10;
  localparam logic [1:0] MAX_BURSTS = 2'h3;
endpackage : power_save_pkg

// ---- hdl/sleep_lfsr.sv ----
/*
  Free-running 16-bit LFSR giving pseudo-random jitter for sleep times.
  Assumes nothing beyond the core clock and reset.
*/
`timescale 1ns/1ps
module sleep_lfsr (
  input wire logic i_clk,
  input wire logic i_srst,
  output logic [15:0] o_value
);
  logic fb;
  // Taps 16,15,13,4 give a maximal sequence
  assign fb = o_value[15] ^ o_value[14] ^ o_value[12] ^ o_value[3];
  // ****************************************************************
  // Shift register; nonzero seed so it never locks up
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_value <= 16'hACE1;
    end else begin
      o_value <= {o_value[14:0], fb};
    end
  end
endmodule : sleep_lfsr

// ---- verif/link_partner_model.sv ----
/*
  Behavioural copper link partner on the twisted-pair side of one port.
  Assumes the core clock; energy and link follow a seen pulse burst.
*/
`timescale 1ns/1ps
module link_partner_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_flp_burst,
  input wire logic i_alive,
  output logic o_energy,
  output logic o_link_up
);
  logic armed_reg;
  logic [5:0] cnt_reg;
  // A sleeping partner wakes only on a burst; unplug drops everything at once
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_alive) begin
      armed_reg <= 1'b0;
      cnt_reg <= 6'h00;
      o_energy <= 1'b0;
      o_link_up <= 1'b0;
    end else begin
      if (i_flp_burst) armed_reg <= 1'b1;
      if (armed_reg && cnt_reg != 6'h3F) cnt_reg <= cnt_reg + 6'h01;
      o_energy <= armed_reg && cnt_reg >= 6'h04;
      o_link_up <= armed_reg && cnt_reg >= 6'h18; // Link trails energy
    end
  end
endmodule : link_partner_model

// ---- verif/phy_link_power_save_fsm_tb_top.sv ----
/*
  Self-checking bench for the per-port power-save state machine.
  Assumes a shortened ms tick (MS cycles) and the partner model.
*/
`timescale 1ns/1ps
module phy_link_power_save_fsm_tb_top;
  import power_save_pkg::*;
  localparam int MS = 8;
  logic clk = 1'b0;
  logic srst, wr, rd, alive, energy, link_up, low_power, manual_pd, flp, pair_b, last;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [31:0] seed = 32'h0000_003F;
  logic [2:0] state;
  int n_mismatch = 0;
  int comparisons = 0;
  int n, k;
  // ****************************************************************
  // Clock, design and partner
  // ****************************************************************
  always #2.5 clk = ~clk;
  phy_link_power_save_fsm #(.MS_CYCLES(MS)) u_phy_link_power_save_fsm (
    .I_REF_CLK(clk), .I_SRST(srst), .I_MEDIA_ENERGY(energy), .I_LINK_UP(link_up),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_LOW_POWER(low_power), .O_MANUAL_PD(manual_pd), .O_FLP_BURST(flp),
    .O_PAIR_B(pair_b), .O_STATE(state));
  link_partner_model u_link_partner_model (.i_clk(clk), .i_srst(srst), .i_flp_burst(flp),
    .i_alive(alive), .o_energy(energy), .o_link_up(link_up));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift
  // Control word as it reads back: bits outside the mask read zero
  function automatic logic [31:0] exp_ctrl(input logic [31:0] d);
    return d & CTRL_MASK;
  endfunction : exp_ctrl
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : in_range
  // Master drives just after the edge; one-cycle strobes
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Bounded wait; legality of state and power flag watched every cycle
  task automatic wait_state(input logic [2:0] s, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1 cnt++;
      if (!(state inside {3'b001, 3'b010, 3'b100}) || low_power !== (state != 3'b100))
        check({29'h0, state}, 32'hF);
    end while (state !== s && cnt < lim);
    if (state !== s) begin
      check({29'h0, state}, {29'h0, s});
      print_verdict();
    end
  endtask : wait_state
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    srst = 1'b1; wr = 1'b0; rd = 1'b0; alive = 1'b0; addr = 8'h00; wdata = 32'h0;
    repeat (3) @(posedge clk);
    #1 check({29'h0, state}, 32'h1);
    check({31'h0, low_power}, 32'h1);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_reg(ADDR_CTRL, rv);
    check(rv, CTRL_RESET);
    // Random control words read back through the mask
    for (k = 0; k < 8; k++) begin
      seed = xorshift(seed);
      wr_reg(ADDR_CTRL, seed);
      rd_reg(ADDR_CTRL, rv);
      check(rv, exp_ctrl(seed));
      check({31'h0, manual_pd}, {31'h0, seed[CTRL_PD_BIT]});
    end
    // Unmapped places: write ignored, read zero, data stands one cycle
    wr_reg(ADDR_CTRL, 32'hFFFF_FFFF);
    wr_reg(8'h08, 32'h0);
    rd_reg(8'h08, rv);
    check(rv, 32'h0);
    rd_reg(ADDR_CTRL, rv);
    check(rv, CTRL_MASK);
    @(posedge clk);
    #1 check(rdata, 32'h0);
    wr_reg(ADDR_CTRL, 32'h0);
    wait_state(ST_NORM, 10, n);
    // Mid-run reset: low power first, then the disabled port goes normal
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check({29'h0, state}, 32'h1);
    @(posedge clk);
    srst <= 1'b0;
    wait_state(ST_NORM, 10, n);
    check(n, 1);
    // Enabled with no partner: link timeout, sleep, then three bursts
    wr_reg(ADDR_CTRL, 32'h0C7);
    wait_state(ST_LOW, 1100 * MS, n);
    in_range(n, 999 * MS, 1001 * MS + 4);
    check({31'h0, manual_pd}, 32'h1);
    wait_state(ST_WAKE, 1100 * MS, n);
    in_range(n, 919 * MS, 1061 * MS + 4);
    k = 0;
    n = 0;
    last = pair_b;
    while (state === ST_WAKE && n < 100 * MS) begin
      @(posedge clk);
      #1 n++;
      if (flp === 1'b1) begin
        k++;
        if (k == 1) check(n, 1);
        check({31'h0, pair_b}, {31'h0, ~last});
        last = pair_b;
      end
    end
    check(k, 3);
    in_range(n, 63 * MS, 65 * MS + 4);
    if (state === ST_WAKE) print_verdict();
    // Partner wakes on a burst; energy takes the sync path into normal
    alive <= 1'b1;
    wait_state(ST_WAKE, 1100 * MS, n);
    n = 0;
    while (energy !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    if (energy !== 1'b1) begin
      check({31'h0, energy}, 32'h1);
      print_verdict();
    end
    repeat (2) @(posedge clk);
    #1 check({31'h0, state === ST_NORM}, 32'h0);
    @(posedge clk);
    #1 check({29'h0, state}, {29'h0, ST_NORM});
    repeat (30) @(posedge clk);
    rd_reg(ADDR_STATUS, rv);
    check(rv & 32'h1F, 32'h1C);
    // Autonegotiation dropped in normal: unplug keeps normal
    wr_reg(ADDR_CTRL, 32'h0C5);
    alive <= 1'b0;
    repeat (1100 * MS) @(posedge clk);
    #1 check({29'h0, state}, {29'h0, ST_NORM});
    // Forced mode from low power, with the longer sleep code this time
    wr_reg(ADDR_CTRL, 32'h0D7);
    wait_state(ST_LOW, 1100 * MS, n);
    wr_reg(ADDR_CTRL, 32'h0D5);
    wait_state(ST_WAKE, 2100 * MS, n);
    in_range(n, 1919 * MS, 2061 * MS + 4);
    alive <= 1'b1;
    wait_state(ST_NORM, 100 * MS, n);
    alive <= 1'b0;
    repeat (1100 * MS) @(posedge clk);
    #1 check({29'h0, state}, {29'h0, ST_NORM});
    print_verdict();
  end
endmodule : phy_link_power_save_fsm_tb_top
